// *** hw/bit_timer.sv ***
// bit period timer: end-of-bit tick, mid-bit strobe and infrared pulse window
`timescale 1ns/1ps

module bit_timer #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             restart,
	input  wire logic [WIDTH-1:0] divisor,
	output logic                  tick,
	output logic                  mid,
	output logic                  pulse
);

	logic [WIDTH-1:0] count;
	logic [WIDTH+1:0] pulse_len;

	// parameter limit, refused at elaboration
	if (WIDTH < 4)
		$error("bit_timer: WIDTH below 4 cannot hold a usable divisor");

	// cycle counter within one bit period
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= '0;
		else if (restart || tick)
			count <= '0;
		else
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// three sixteenths of the bit period
	assign pulse_len = ({2'b00, divisor} + {1'b0, divisor, 1'b0}) >> 4;

	assign tick  = (count >= divisor - {{(WIDTH-1){1'b0}}, 1'b1});
	assign mid   = (count == (divisor >> 1));
	assign pulse = ({2'b00, count} < pulse_len);

endmodule : bit_timer

// *** hw/usart_frame_control.sv ***
// usart frame control: tx enable handshake, parity, infrared coding, start-of-frame wake, collision detect
//
// Behaviour
// RULE1: writing transmit enable one while enabled raises sync pending until transmitter runs
// RULE2: transmit enable reads zero while off or starting, one when on or waiting
// RULE3: transmit enable writes accepted whether or not the usart is enabled
// RULE4: parity type bit 13 selects even (0) or odd (1) when format is one
// RULE5: transmitter appends computed parity bit to every frame when parity enabled
// RULE6: receiver checks data plus parity bit, flags parity error on mismatch
// RULE7: encoding bit 10 selects plain (0) or infrared (1) line coding
// RULE8: start-of-frame bit 9 gates wake on start bit; zero disables it entirely
// RULE9: receive-complete and receive-start enables each allow wake, both may be set
// RULE10: software never sets start detect with both receive wake enables cleared
// RULE11: collision detect bit 8 enables collision check; these bits act without synchronisation (check runs only while encoding bit 10 is zero)
// RULE12: no parity check or parity error when format selects frames without parity
`timescale 1ns/1ps
`include "usart_frame_map.svh"

module usart_frame_control #(
	parameter int DATA_BITS = 8,
	parameter int BAUD_W    = 16
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic        rxd,
	output logic             txd,
	output logic             irq,
	output logic             wake
);

	localparam int IDX_W = $clog2(DATA_BITS);

	logic                      usart_en;
	logic [3:0]                frame_format_field;
	logic                      collision_detect_en;
	logic                      start_frame_detect_en;
	logic                      irda_encoding_select;
	logic                      parity_type_select;
	logic                      transmit_enable_bit;
	logic                      tx_active;
	logic                      control_b_sync_pending;
	logic [1:0]                sync_cnt;
	logic [`INT_BITS-1:0]      int_mask;
	logic [`INT_BITS-1:0]      int_status;
	logic [`INT_BITS-1:0]      events;
	logic [BAUD_W-1:0]         baud_div;
	logic [DATA_BITS-1:0]      rx_data;
	logic [31:0]               next_readdata;
	logic                      wr_en;
	logic                      rd_en;
	logic                      parity_on;
	logic                      rxd_meta;
	logic                      rxd_s;
	logic                      rxd_prev;
	usart_frame_pkg::tx_state_t tx_state;
	usart_frame_pkg::rx_state_t rx_state;
	logic [DATA_BITS-1:0]      tx_shift;
	logic [IDX_W-1:0]          tx_idx;
	logic                      tx_par;
	logic                      tx_bit;
	logic                      tx_go;
	logic                      tx_tick;
	logic                      tx_mid;
	logic                      tx_pulse;
	logic [DATA_BITS-1:0]      rx_shift;
	logic [IDX_W-1:0]          rx_idx;
	logic                      rx_par;
	logic                      rx_bit;
	logic                      rx_restart;
	logic                      rx_tick;
	logic                      rx_mid;
	logic                      mid_sample;
	logic                      low_seen;
	logic                      ev_txc;
	logic                      ev_rxc;
	logic                      ev_rxs;
	logic                      ev_parity_error_flag;
	logic                      ev_coll;

	// parameter limits, refused at elaboration
	if (DATA_BITS < 5 || DATA_BITS > 9)
		$error("usart_frame_control: DATA_BITS must lie between 5 and 9");
	if (BAUD_W < 4 || BAUD_W > 32)
		$error("usart_frame_control: BAUD_W must lie between 4 and 32");

	// merge write data into a register under the byte enables
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge_be = (old & ~m) | (wd & m);
	endfunction : merge_be

	////////////////////////////////////////////////////////////////////////////
	// bus slave

	// one wait cycle, then answer; the access completes where waitrequest is low
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);
	end

	assign wr_en = write && !waitrequest;
	assign rd_en = (read || write) && waitrequest;

	// read mux; unmapped offsets read zero
	always_comb
	begin
		next_readdata = 32'h0000_0000;
		case (address)
			`OFS_CONTROL_A:
			begin
				next_readdata[`CONTROL_A_ENABLE_BIT] = usart_en;
				next_readdata[`CONTROL_A_FRAME_FORMAT_FIELD_MSB:`CONTROL_A_FRAME_FORMAT_FIELD_LSB] = frame_format_field;
			end
			`OFS_CONTROL_B:
			begin
				next_readdata[`CONTROL_B_COLL_BIT]  = collision_detect_en;
				next_readdata[`CONTROL_B_START_FRAME_DETECT_EN_BIT]  = start_frame_detect_en;
				next_readdata[`CONTROL_B_ENC_BIT]   = irda_encoding_select;
				next_readdata[`CONTROL_B_PTYPE_BIT] = parity_type_select;
				next_readdata[`CONTROL_B_TRANSMIT_ENABLE_BIT_BIT]  = tx_active || (transmit_enable_bit && !usart_en); // RULE2
			end
			`OFS_INT_MASK:    next_readdata[`INT_BITS-1:0] = int_mask;
			`OFS_INT_STATUS:  next_readdata[`INT_BITS-1:0] = int_status;
			`OFS_SYNC_STATUS:
			begin
				next_readdata[`SYNC_CONTROL_B_BIT]  = control_b_sync_pending;
				next_readdata[`SYNC_TXBUSY_BIT] = (tx_state != usart_frame_pkg::TX_IDLE);
				next_readdata[`SYNC_RXBUSY_BIT] = (rx_state != usart_frame_pkg::RX_IDLE);
			end
			`OFS_DATA:        next_readdata[DATA_BITS-1:0] = rx_data;
			`OFS_BAUD:        next_readdata[BAUD_W-1:0] = baud_div;
			default:          next_readdata = 32'h0000_0000;
		endcase
	end

	// read data captured for the answer cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			readdata <= 32'h0000_0000;
		else if (rd_en)
			readdata <= read ? next_readdata : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	// control_a: usart enable and frame format
	always_ff @(posedge clk or negedge rst_n)
	begin
		logic [31:0] v;
		v = 32'h0000_0000;
		if (!rst_n)
		begin
			usart_en           <= 1'b0;
			frame_format_field <= `FRAME_FORMAT_FIELD_NO_PARITY;
		end
		else if (wr_en && address == `OFS_CONTROL_A)
		begin
			v = merge_be(next_readdata, writedata, byteenable);
			usart_en           <= v[`CONTROL_A_ENABLE_BIT];
			frame_format_field <= v[`CONTROL_A_FRAME_FORMAT_FIELD_MSB:`CONTROL_A_FRAME_FORMAT_FIELD_LSB];
		end
	end

	// control_b: taken at once, no enable protection, no synchronisation for the option bits
	always_ff @(posedge clk or negedge rst_n)
	begin
		logic [31:0] v;
		v = 32'h0000_0000;
		if (!rst_n)
		begin
			collision_detect_en   <= 1'b0;
			start_frame_detect_en <= 1'b0;
			irda_encoding_select  <= 1'b0;
			parity_type_select    <= 1'b0;
			transmit_enable_bit   <= 1'b0;
		end
		else if (wr_en && address == `OFS_CONTROL_B) // RULE3
		begin
			v = merge_be({15'h0000, transmit_enable_bit, next_readdata[15:0]}, writedata, byteenable);
			collision_detect_en   <= v[`CONTROL_B_COLL_BIT];  // RULE11
			start_frame_detect_en <= v[`CONTROL_B_START_FRAME_DETECT_EN_BIT];  // RULE8
			irda_encoding_select  <= v[`CONTROL_B_ENC_BIT];   // RULE7
			parity_type_select    <= v[`CONTROL_B_PTYPE_BIT]; // RULE4
			transmit_enable_bit   <= v[`CONTROL_B_TRANSMIT_ENABLE_BIT_BIT];
		end
	end

	// mask and baud divisor
	always_ff @(posedge clk or negedge rst_n)
	begin
		logic [31:0] v;
		v = 32'h0000_0000;
		if (!rst_n)
		begin
			int_mask <= '0;
			baud_div <= BAUD_W'(`BAUD_RESET);
		end
		else if (wr_en)
		begin
			v = merge_be(next_readdata, writedata, byteenable);
			if (address == `OFS_INT_MASK)
				int_mask <= v[`INT_BITS-1:0];
			if (address == `OFS_BAUD && v[BAUD_W-1:0] > BAUD_W'(3))
				baud_div <= v[BAUD_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmitter enable handshake

	// transmitter follows the request after a fixed settling delay
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_active <= 1'b0;
			sync_cnt  <= 2'h0;
		end
		else if ((transmit_enable_bit && usart_en) == tx_active)
			sync_cnt <= 2'h0;
		else if (sync_cnt == 2'(`TX_SYNC_CYCLES - 1))
		begin
			tx_active <= transmit_enable_bit && usart_en;
			sync_cnt  <= 2'h0;
		end
		else
			sync_cnt <= sync_cnt + 2'h1;
	end

	// pending flag from an enabling write until the transmitter runs; a new write wins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			control_b_sync_pending <= 1'b0;
		else if (wr_en && address == `OFS_CONTROL_B && byteenable[2] && writedata[`CONTROL_B_TRANSMIT_ENABLE_BIT_BIT] && usart_en)
			control_b_sync_pending <= 1'b1; // RULE1
		else if (tx_active || !usart_en)
			control_b_sync_pending <= 1'b0; // RULE1
	end

	////////////////////////////////////////////////////////////////////////////
	// receive pin synchroniser and bit timers

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxd_meta <= 1'b1;
			rxd_s    <= 1'b1;
			rxd_prev <= 1'b1;
		end
		else
		begin
			rxd_meta <= rxd;
			rxd_s    <= rxd_meta;
			rxd_prev <= rxd_s;
		end
	end

	bit_timer #(.WIDTH(BAUD_W)) tx_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.restart (tx_go),
		.divisor (baud_div),
		.tick    (tx_tick),
		.mid     (tx_mid),
		.pulse   (tx_pulse)
	);

	bit_timer #(.WIDTH(BAUD_W)) rx_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.restart (rx_restart),
		.divisor (baud_div),
		.tick    (rx_tick),
		.mid     (rx_mid),
		.pulse   ()
	);

	////////////////////////////////////////////////////////////////////////////
	// transmitter

	assign parity_on = (frame_format_field == `FRAME_FORMAT_FIELD_WITH_PARITY);
	assign tx_go = wr_en && address == `OFS_DATA && tx_active && tx_state == usart_frame_pkg::TX_IDLE;

	// current line bit of the frame
	always_comb
	begin
		case (tx_state)
			usart_frame_pkg::TX_START:  tx_bit = 1'b0;
			usart_frame_pkg::TX_DATA:   tx_bit = tx_shift[0];
			usart_frame_pkg::TX_PARITY: tx_bit = tx_par;
			default:                    tx_bit = 1'b1;
		endcase
	end

	assign ev_coll = collision_detect_en && !irda_encoding_select && tx_mid && // RULE11
		tx_state != usart_frame_pkg::TX_IDLE && rxd_s != tx_bit;
	assign ev_txc = tx_state == usart_frame_pkg::TX_STOP && tx_tick;

	// frame sequencer; a collision drops the frame
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state <= usart_frame_pkg::TX_IDLE;
			tx_shift <= '0;
			tx_idx   <= '0;
			tx_par   <= 1'b0;
		end
		else if (tx_go)
		begin
			tx_state <= usart_frame_pkg::TX_START;
			tx_shift <= writedata[DATA_BITS-1:0];
			tx_par   <= (^writedata[DATA_BITS-1:0]) ^ parity_type_select; // RULE5
			tx_idx   <= '0;
		end
		else if (ev_coll || !tx_active)
			tx_state <= usart_frame_pkg::TX_IDLE;
		else if (tx_tick)
		begin
			case (tx_state)
				usart_frame_pkg::TX_START:
					tx_state <= usart_frame_pkg::TX_DATA;
				usart_frame_pkg::TX_DATA:
				begin
					tx_shift <= tx_shift >> 1;
					tx_idx   <= tx_idx + {{(IDX_W-1){1'b0}}, 1'b1};
					if (tx_idx == IDX_W'(DATA_BITS - 1))
						tx_state <= parity_on ? usart_frame_pkg::TX_PARITY : usart_frame_pkg::TX_STOP; // RULE5
				end
				usart_frame_pkg::TX_PARITY:
					tx_state <= usart_frame_pkg::TX_STOP;
				default:
					tx_state <= usart_frame_pkg::TX_IDLE;
			endcase
		end
	end

	// line driver: plain level or short low pulse per zero bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			txd <= 1'b1;
		else if (irda_encoding_select)
			txd <= !(!tx_bit && tx_pulse); // RULE7
		else
			txd <= tx_bit;
	end

	////////////////////////////////////////////////////////////////////////////
	// receiver

	assign rx_restart = usart_en && rx_state == usart_frame_pkg::RX_IDLE && rxd_prev && !rxd_s;
	assign ev_rxs = rx_restart;
	assign rx_bit = irda_encoding_select ? !low_seen : mid_sample; // RULE7
	assign ev_rxc = rx_state == usart_frame_pkg::RX_STOP && rx_tick;
	assign ev_parity_error_flag = ev_rxc && parity_on && ((^rx_shift) ^ rx_par) != parity_type_select; // RULE6 RULE12

	// mid-bit sample and infrared pulse catcher
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mid_sample <= 1'b1;
			low_seen   <= 1'b0;
		end
		else
		begin
			if (rx_mid)
				mid_sample <= rxd_s;
			if (rx_tick || rx_restart)
				low_seen <= 1'b0;
			else if (!rxd_s)
				low_seen <= 1'b1;
		end
	end

	// frame sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state <= usart_frame_pkg::RX_IDLE;
			rx_shift <= '0;
			rx_idx   <= '0;
			rx_par   <= 1'b0;
		end
		else if (rx_restart)
		begin
			rx_state <= usart_frame_pkg::RX_START;
			rx_idx   <= '0;
		end
		else if (!usart_en)
			rx_state <= usart_frame_pkg::RX_IDLE;
		else if (rx_state == usart_frame_pkg::RX_START && rx_mid && !irda_encoding_select && rxd_s)
			rx_state <= usart_frame_pkg::RX_IDLE; // false start
		else if (rx_tick)
		begin
			case (rx_state)
				usart_frame_pkg::RX_START:
					rx_state <= usart_frame_pkg::RX_DATA;
				usart_frame_pkg::RX_DATA:
				begin
					rx_shift <= {rx_bit, rx_shift[DATA_BITS-1:1]};
					rx_idx   <= rx_idx + {{(IDX_W-1){1'b0}}, 1'b1};
					if (rx_idx == IDX_W'(DATA_BITS - 1))
						rx_state <= parity_on ? usart_frame_pkg::RX_PARITY : usart_frame_pkg::RX_STOP; // RULE12
				end
				usart_frame_pkg::RX_PARITY:
				begin
					rx_par   <= rx_bit;
					rx_state <= usart_frame_pkg::RX_STOP;
				end
				default:
					rx_state <= usart_frame_pkg::RX_IDLE;
			endcase
		end
	end

	// received word holding register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_data <= '0;
		else if (ev_rxc)
			rx_data <= rx_shift;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts and wake

	always_comb
	begin
		events = '0;
		events[`INT_TXC_BIT]  = ev_txc;
		events[`INT_RXC_BIT]  = ev_rxc;
		events[`INT_RXS_BIT]  = ev_rxs;
		events[`INT_PARITY_ERROR_FLAG_BIT] = ev_parity_error_flag; // RULE6
		events[`INT_COLL_BIT] = ev_coll;
	end

	// sticky flags, write one to clear, a new event wins over the clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			int_status <= '0;
		else if (wr_en && address == `OFS_INT_STATUS && byteenable[0])
			int_status <= (int_status & ~writedata[`INT_BITS-1:0]) | events;
		else
			int_status <= int_status | events;
	end

	// level interrupt while any unmasked flag is set
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(int_status & int_mask);
	end

	// wake pulse on enabled start or completion; reserved setting wakes on nothing
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wake <= 1'b0;
		else
			wake <= start_frame_detect_en && // RULE8 RULE10
				((int_mask[`INT_RXS_BIT] && ev_rxs) || (int_mask[`INT_RXC_BIT] && ev_rxc)); // RULE9
	end

endmodule : usart_frame_control

// *** hw/usart_frame_map.svh ***
// register offsets, field positions, reset values and timing counts of the usart frame control block
`ifndef USART_FRAME_MAP_SVH
`define USART_FRAME_MAP_SVH

// byte offsets on the register bus
`define OFS_CONTROL_A      5'h00
`define OFS_CONTROL_B      5'h04
`define OFS_INT_MASK       5'h08
`define OFS_INT_STATUS     5'h0C
`define OFS_SYNC_STATUS    5'h10
`define OFS_DATA           5'h14
`define OFS_BAUD           5'h18

// control_a fields
`define CONTROL_A_ENABLE_BIT   0
`define CONTROL_A_FRAME_FORMAT_FIELD_LSB     24
`define CONTROL_A_FRAME_FORMAT_FIELD_MSB     27
`define FRAME_FORMAT_FIELD_NO_PARITY     4'h0
`define FRAME_FORMAT_FIELD_WITH_PARITY   4'h1

// control_b fields
`define CONTROL_B_COLL_BIT     8
`define CONTROL_B_START_FRAME_DETECT_EN_BIT     9
`define CONTROL_B_ENC_BIT      10
`define CONTROL_B_PTYPE_BIT    13
`define CONTROL_B_TRANSMIT_ENABLE_BIT_BIT     16

// interrupt status and mask bits
`define INT_TXC_BIT        0
`define INT_RXC_BIT        1
`define INT_RXS_BIT        2
`define INT_PARITY_ERROR_FLAG_BIT       3
`define INT_COLL_BIT       4
`define INT_BITS           5

// sync status bits
`define SYNC_CONTROL_B_BIT     2
`define SYNC_TXBUSY_BIT    8
`define SYNC_RXBUSY_BIT    9

// reset values and timing
`define BAUD_RESET         16'h0010
`define TX_SYNC_CYCLES     3

`endif

// *** hw/usart_frame_pkg.sv ***
// types shared by the usart frame control block
package usart_frame_pkg;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage : usart_frame_pkg

// *** tb/serial_peer.sv ***
// remote serial peer: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps

module serial_peer #(
	parameter int BIT_CLKS = 8
) (
	input  wire logic clk,
	input  wire logic txd,
	input  wire logic par_on,
	output logic      rxd
);
	logic [8:0] got = 9'h0;
	int         low_run = 0;
	int         max_run = 0;

	initial rxd = 1'b1;

	// send one frame lsb first, parity bit only with parity on
	task automatic send(input logic [7:0] d, input logic p);
		logic [10:0] f;
		f = {1'b1, p, d, 1'b0};
		for (int i = 0; i < 11; i++)
			if (i != 9 || par_on)
			begin
				rxd <= f[i];
				repeat (BIT_CLKS) @(posedge clk);
			end
	endtask : send

	// send one infrared frame: a short low pulse for each zero bit, no parity
	task automatic send_ir(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxd <= f[i];
			repeat (3) @(posedge clk);
			rxd <= 1'b1;
			repeat (BIT_CLKS - 3) @(posedge clk);
		end
	endtask : send_ir

	// capture data and parity of each frame at bit centres
	always
	begin
		@(negedge txd);
		repeat (BIT_CLKS / 2) @(posedge clk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (BIT_CLKS) @(posedge clk);
			if (i < 8 || par_on)
				got[i] = txd;
		end
		repeat (BIT_CLKS) @(posedge clk);
	end

	// longest low stretch on txd, for line coding checks
	always @(posedge clk)
	begin
		low_run <= txd ? 0 : low_run + 1;
		if (low_run > max_run)
			max_run <= low_run;
	end
endmodule : serial_peer

// *** tb/tb_usart_frame_control.sv ***
// testbench of the usart frame control block
`timescale 1ns/1ps
`include "usart_frame_map.svh"

module tb_usart_frame_control;
	localparam int BIT = 8;
	logic        clk = 1'b0;
	logic        rst_n;
	logic [4:0]  address;
	logic        read;
	logic        write;
	logic [3:0]  byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        rxd;
	logic        txd;
	logic        irq;
	logic        wake;
	logic        par_on;
	logic [31:0] rd;
	logic [7:0]  tx_d [2] = '{8'h55, 8'hA7};
	int          bad_count = 0;
	int          n_checks = 0;
	int          wake_cnt = 0;

	always #20 clk = ~clk;

	usart_frame_control DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.rxd(rxd), .txd(txd), .irq(irq), .wake(wake));
	serial_peer #(.BIT_CLKS(BIT)) peer (.clk(clk), .txd(txd), .par_on(par_on), .rxd(rxd));

	// count wake pulses
	always @(posedge clk)
		if (wake === 1'b1)
			wake_cnt++;

	////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr_n, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		write      <= wr_n;
		read       <= !wr_n;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			bad_count++;
		rd = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
		bus(1'b1, a, d, be);
	endtask : wr

	task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		check(rd & m, e);
	endtask : rc

	// poll a status flag, then clear it by writing one
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, `OFS_INT_STATUS, 32'h0, 4'hF);
			n++;
		end
		while (rd[b] !== 1'b1 && n < 200);
		check(rd[b], 1'b1);
		wr(`OFS_INT_STATUS, 32'h1 << b, 4'h1);
	endtask : wait_flag

	task automatic rx_case(input logic [7:0] d, input logic p, input logic parity_error_flag);
		peer.send(d, p);
		wait_flag(`INT_RXC_BIT);
		rc(`OFS_DATA, 32'hFF, {24'h0, d});
		rc(`OFS_INT_STATUS, 32'h8, {28'h0, parity_error_flag, 3'h0});
		wr(`OFS_INT_STATUS, 32'h1F, 4'h1);
	endtask : rx_case

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	////////////////////////////////////////
	initial
	begin
		int         n;
		logic [4:0] m;
		rst_n = 1'b0;
		{read, write, address, byteenable, writedata} = '0;
		par_on = 1'b1;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rc(`OFS_BAUD, 32'hFFFF, {16'h0000, `BAUD_RESET});
		rc(`OFS_CONTROL_A, 32'hFFFFFFFF, 32'h0);
		wr(5'h1C, 32'hFFFFFFFF);
		rc(5'h1C, 32'hFFFFFFFF, 32'h0);
		wr(`OFS_BAUD, BIT);
		$display("test registers done");
		wr(`OFS_CONTROL_B, 32'h10000);
		rc(`OFS_CONTROL_B, 32'h10000, 32'h10000);
		rc(`OFS_SYNC_STATUS, 32'h4, 32'h0);
		wr(`OFS_CONTROL_B, 32'h0);
		wr(`OFS_CONTROL_A, 32'h01000001);
		wr(`OFS_CONTROL_B, 32'h10000);
		rc(`OFS_SYNC_STATUS, 32'h4, 32'h4);
		repeat (8) @(posedge clk);
		rc(`OFS_SYNC_STATUS, 32'h4, 32'h0);
		rc(`OFS_CONTROL_B, 32'h10000, 32'h10000);
		$display("test transmit enable done");
		for (int i = 0; i < 4; i++)
		begin
			wr(`OFS_CONTROL_B, i[1] ? 32'h2000 : 32'h0, 4'h2);
			wr(`OFS_DATA, {24'h0, tx_d[i[0]]});
			wait_flag(`INT_TXC_BIT);
			check({23'h0, peer.got}, {23'h0, ^tx_d[i[0]] ^ i[1], tx_d[i[0]]});
		end
		$display("test transmit parity done");
		wr(`OFS_CONTROL_B, 32'h0, 4'h2);
		rx_case(8'h3C, 1'b0, 1'b0);
		rx_case(8'h3C, 1'b1, 1'b1);
		wr(`OFS_CONTROL_A, 32'h1);
		par_on <= 1'b0;
		rx_case(8'h3D, 1'b1, 1'b0);
		$display("test receive parity done");
		wr(`OFS_INT_MASK, 32'h2);
		peer.send(8'h11, 1'b0);
		n = 0;
		while (irq !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		check(irq, 1'b1);
		wr(`OFS_INT_STATUS, 32'h1F, 4'h1);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		$display("test interrupt done");
		// both receive wake enables clear with detect on is never set up
		for (int i = 0; i < 4; i++)
		begin
			m = (i == 0) ? 5'h2 : 5'(2 * i);
			wr(`OFS_CONTROL_B, (i > 0) ? 32'h200 : 32'h0, 4'h2);
			wr(`OFS_INT_MASK, {27'h0, m});
			wake_cnt = 0;
			peer.send(8'h5A, 1'b0);
			wait_flag(`INT_RXC_BIT);
			check(wake_cnt, (i > 0) ? 32'(m[1]) + 32'(m[2]) : 32'h0);
			wr(`OFS_INT_MASK, 32'h0);
			repeat (2) @(posedge clk);
			check(irq, 1'b0);
			wr(`OFS_INT_STATUS, 32'h1F, 4'h1);
		end
		$display("test wake done");
		for (int i = 0; i < 2; i++)
		begin
			wr(`OFS_CONTROL_B, i ? 32'h0 : 32'h400, 4'h2);
			if (i == 0)
			begin
				peer.send_ir(8'hA5);
				wait_flag(`INT_RXC_BIT);
				rc(`OFS_DATA, 32'hFF, 32'hA5);
			end
			peer.max_run = 0;
			wr(`OFS_DATA, 32'h0);
			wait_flag(`INT_TXC_BIT);
			check(i ? peer.max_run >= 9 * BIT : peer.max_run < BIT, 1'b1);
		end
		$display("test line coding done");
		wr(`OFS_CONTROL_B, 32'h100, 4'h2);
		fork
			peer.send(8'h00, 1'b0);
			wr(`OFS_DATA, 32'hFF);
		join
		wait_flag(`INT_COLL_BIT);
		$display("test collision done");
		complete_run();
	end

	// watchdog against a hung handshake
	initial
	begin
		repeat (30000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule : tb_usart_frame_control

// *** tb/usart_frame_props.sv ***
// port checker for the usart frame control block
`timescale 1ns/1ps
`include "usart_frame_map.svh"

module usart_frame_props (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [4:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        irq,
	input wire logic        wake
);
	logic       start_frame_detect_en_sh;
	logic [4:0] mask_sh;

	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////
	// copy of the start detect bit as written
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			start_frame_detect_en_sh <= 1'b0;
		else if (write && !waitrequest && address == `OFS_CONTROL_B && byteenable[1])
			start_frame_detect_en_sh <= writedata[`CONTROL_B_START_FRAME_DETECT_EN_BIT];

	// copy of the interrupt mask as written
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			mask_sh <= 5'h0;
		else if (write && !waitrequest && address == `OFS_INT_MASK && byteenable[0])
			mask_sh <= writedata[4:0];

	// bus steps
	sequence req_wait;
		(read || write) && waitrequest;
	endsequence
	sequence acc_done;
		(read || write) && !waitrequest;
	endsequence

	////////////////////////////////////////
	a_one_wait_cycle: assert property (req_wait |=> !waitrequest)
		else $error("answer not one cycle after request");
	a_ack_one_cycle: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_idle_no_ack: assert property (!(read || write) && waitrequest |=> waitrequest)
		else $error("answer without request");
	a_unmapped_reads_zero: assert property ((acc_done ##0 (read && address > 5'h18)) |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_mask_off_quiet: assert property ((acc_done ##0 (write && address == `OFS_INT_MASK && byteenable[0]
		&& writedata[4:0] == 5'h0)) |-> ##2 !irq [*2])
		else $error("irq high with mask cleared");
	a_irq_needs_mask: assert property (irq |-> $past(mask_sh) != 5'h0)
		else $error("irq without mask bit");
	a_wake_one_pulse: assert property (wake |=> !wake)
		else $error("wake longer than one cycle");
	a_wake_needs_start_frame_detect_en: assert property (wake |-> $past(start_frame_detect_en_sh))
		else $error("wake with start detect off");
	a_wake_needs_enable: assert property (wake |-> $past(mask_sh[1] || mask_sh[2]))
		else $error("wake without receive enable");
endmodule : usart_frame_props

bind usart_frame_control usart_frame_props u_props (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
	.write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .rxd(rxd), .txd(txd), .irq(irq), .wake(wake));
